//--- core/ims_dev.sv
// serial memory slave end: start/stop, address word, acks, byte array
//
// How it works
// R1: sample on scl rise, drive on fall
// R2: data pin only ever pulled low
// R3: controller alone starts and clocks transfers
// R4: data changes only while scl low
// R5: sda fall, scl high: start
// R6: sda rise, scl high: stop, standby
// R7: receiver acks low on ninth clock
// R8: transmitter releases data on ack clock
// R9: stop before ack abandons the operation
// R10: after nack release bus, await stop/start
// R11: address word: type, select, direction
// R12: upper four bits must match type
// R13: select bits match straps, msb first
// R14: open straps read as low
// R15: eighth bit zero writes, one reads
// R16: mismatch: no ack, standby till start
// R17: write protect high blocks array writes
// R18: no busy time after write stop
// R19: array holds 32768 bytes
// R20: write: take 8 then ack; read: send 8
// R21: ack held low fall to fall
// R22: mid-transfer start restarts address word
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module ims_dev #(
  parameter logic [3:0] TYPE_CODE = ims_pkg::TYPE_CODE_DFLT, // device type code
  parameter int         DEPTH     = ims_pkg::MEM_DEPTH       // bytes in array
) (
  input  wire logic       clk,                 // system clock
  input  wire logic       rst_b,               // async reset, active low
  ims_link_if.dev         link,                // two-wire link
  input  wire logic [2:0] select_strap_inputs, // select straps, low if open
  input  wire logic       write_protect,       // high blocks array writes
  output logic            active               // addressed and in transfer
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_m_reg;
  logic [1:0] pin_s_reg;
  logic [1:0] pin_d_reg;
  logic [3:0] strap_m_reg;
  logic [3:0] strap_s_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_m_reg <= 2'h3;
      pin_s_reg <= 2'h3;
      pin_d_reg <= 2'h3;
    end else begin
      pin_m_reg <= {link.scl, link.sda};
      pin_s_reg <= pin_m_reg;
      pin_d_reg <= pin_s_reg;
    end
  end

  // straps reset low, matching an open pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_m_reg <= 4'h0; // R14
      strap_s_reg <= 4'h0; // R14
    end else begin
      strap_m_reg <= {write_protect, select_strap_inputs};
      strap_s_reg <= strap_m_reg;
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_s     = pin_s_reg[1];
  assign sda_s     = pin_s_reg[0];
  assign scl_rise  = scl_s & ~pin_d_reg[1];
  assign scl_fall  = ~scl_s & pin_d_reg[1];
  // scl high in both samples, so a data edge beside a clock edge is ignored
  assign start_det = scl_s & pin_d_reg[1] & pin_d_reg[0] & ~sda_s; // R5
  assign stop_det  = scl_s & pin_d_reg[1] & ~pin_d_reg[0] & sda_s; // R6

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  ims_pkg::ims_dst_t state_reg;
  logic [3:0]        bit_reg;
  logic [1:0]        idx_reg;
  logic [7:0]        rx_reg;
  logic [7:0]        tx_reg;
  logic              rw_reg;
  logic              mack_reg;
  logic              oe_reg;
  logic              o_reg;
  logic [AW-1:0]     addr_reg;
  logic [7:0]        mem [DEPTH]; // R19
  logic              addr_ok;
  logic              mem_we;
  logic [7:0]        rd_byte;

  assign addr_ok = (rx_reg[7:4] == TYPE_CODE) &                 // R11 R12
                   (rx_reg[3:1] == strap_s_reg[2:0]);           // R13
  assign mem_we  = scl_fall & (state_reg == ims_pkg::IMS_D_RX) &
                   (bit_reg == ims_pkg::LAST_DATA_BIT) &
                   (idx_reg == ims_pkg::IDX_DATA) & ~strap_s_reg[3]; // R17
  assign rd_byte = mem[addr_reg];

  // array is written in the ack-producing edge, so nothing is pending at stop
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[addr_reg] <= rx_reg; // R18
    end
  end

  // capture on the rising clock edge only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_reg   <= 8'h00;
      mack_reg <= 1'b0;
    end else if (scl_rise) begin
      if (bit_reg < ims_pkg::ACK_BIT) begin
        rx_reg <= {rx_reg[6:0], sda_s}; // R1
      end else begin
        mack_reg <= ~sda_s; // R20
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      o_reg <= 1'b0;
    end else begin
      o_reg <= 1'b0; // R2
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ims_pkg::IMS_D_IDLE;
      bit_reg   <= 4'h0;
      idx_reg   <= ims_pkg::IDX_DEV;
      tx_reg    <= 8'h00;
      rw_reg    <= 1'b0;
      oe_reg    <= 1'b0;
      addr_reg  <= '0;
    end else if (start_det) begin
      state_reg <= ims_pkg::IMS_D_RX; // R5 R22
      // the fall that closes the start wraps this to bit 0
      bit_reg   <= 4'hf;              // R22
      rw_reg    <= 1'b0;
      idx_reg   <= ims_pkg::IDX_DEV;
      oe_reg    <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ims_pkg::IMS_D_IDLE; // R6 R9
      oe_reg    <= 1'b0;
    end else if (scl_fall) begin
      // every change of the data pin happens here, on a falling edge
      case (state_reg)
        ims_pkg::IMS_D_RX: begin
          if (bit_reg == ims_pkg::LAST_DATA_BIT) begin
            bit_reg <= ims_pkg::ACK_BIT;
            case (idx_reg)
              ims_pkg::IDX_DEV: begin
                if (addr_ok) begin
                  oe_reg <= 1'b1;      // R7 R21
                  rw_reg <= rx_reg[0]; // R15
                end else begin
                  state_reg <= ims_pkg::IMS_D_IDLE; // R16
                end
              end
              ims_pkg::IDX_ADDR_HI: begin
                oe_reg   <= 1'b1; // R7
                addr_reg <= AW'({rx_reg, addr_reg[7:0]});
              end
              ims_pkg::IDX_ADDR_LO: begin
                oe_reg   <= 1'b1; // R7
                addr_reg <= AW'({addr_reg[AW-1:8], rx_reg});
              end
              default: begin
                // protected writes still ack; the byte is simply dropped
                oe_reg   <= 1'b1; // R7 R20
                addr_reg <= addr_reg + AW'(1);
              end
            endcase
          end else if (bit_reg == ims_pkg::ACK_BIT) begin
            oe_reg  <= 1'b0; // R21
            bit_reg <= 4'h0;
            if (idx_reg == ims_pkg::IDX_DEV && rw_reg) begin
              state_reg <= ims_pkg::IMS_D_TX;
              oe_reg    <= ~rd_byte[7]; // R1 R2
              tx_reg    <= {rd_byte[6:0], 1'b0};
              addr_reg  <= addr_reg + AW'(1);
            end else if (idx_reg != ims_pkg::IDX_DATA) begin
              idx_reg <= idx_reg + 2'h1;
            end
          end else begin
            bit_reg <= bit_reg + 4'h1;
          end
        end
        ims_pkg::IMS_D_TX: begin
          if (bit_reg == ims_pkg::LAST_DATA_BIT) begin
            bit_reg <= ims_pkg::ACK_BIT;
            oe_reg  <= 1'b0; // R8
          end else if (bit_reg == ims_pkg::ACK_BIT) begin
            bit_reg <= 4'h0;
            if (mack_reg) begin
              oe_reg   <= ~rd_byte[7]; // R20
              tx_reg   <= {rd_byte[6:0], 1'b0};
              addr_reg <= addr_reg + AW'(1);
            end else begin
              state_reg <= ims_pkg::IMS_D_IDLE; // R10
            end
          end else begin
            bit_reg <= bit_reg + 4'h1;
            oe_reg  <= ~tx_reg[7]; // R1 R2
            tx_reg  <= {tx_reg[6:0], 1'b0};
          end
        end
        default: begin
          oe_reg <= 1'b0; // R16
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active <= 1'b0;
    end else begin
      active <= (state_reg != ims_pkg::IMS_D_IDLE) &
                ((idx_reg != ims_pkg::IDX_DEV) | rw_reg | oe_reg |
                 (state_reg == ims_pkg::IMS_D_TX));
    end
  end

  assign link.dev_sda_oe = oe_reg;
  assign link.dev_sda_o  = o_reg;

endmodule

//--- core/ims_link_if.sv
// two-wire link between the controller and the memory slave
`timescale 1ns/1ps
interface ims_link_if;
  logic scl;        // serial clock, driven by the controller only
  logic sda;        // resolved data line level (pulled up)
  logic dev_sda_o;  // slave data out, always low
  logic dev_sda_oe; // slave pulls the line
  logic mst_sda_o;  // controller data out, always low
  logic mst_sda_oe; // controller pulls the line

  // wired-and with pull-up: any enabled low driver wins
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (mst_sda_oe & ~mst_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport mst (output scl, input sda, output mst_sda_o, output mst_sda_oe);
endinterface

//--- core/ims_mst.sv
// controller end: makes scl, frames starts, bytes and stops on command
`timescale 1ns/1ps
module ims_mst #(
  parameter int QTR_CYC = ims_pkg::SCL_QTR_CYC // clocks per quarter scl period
) (
  input  wire logic        clk,   // system clock
  input  wire logic        rst_b, // async reset, active low
  ims_link_if.mst          link,  // two-wire link
  input  wire logic [3:0]  addr,  // register address
  input  wire logic [31:0] wdata, // write data
  input  wire logic        wr,    // write strobe
  input  wire logic        rd,    // read strobe
  output logic      [31:0] rdata  // read data, cycle after rd
);

  // ----------------------------------------------------------------
  // line sampling and quarter tick
  // ----------------------------------------------------------------
  logic       sda_m_reg;
  logic       sda_s_reg;
  logic [7:0] qcnt_reg;
  logic       tick;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else begin
      sda_m_reg <= link.sda;
      sda_s_reg <= sda_m_reg;
    end
  end

  assign tick = (qcnt_reg == 8'h00);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      qcnt_reg <= 8'h00;
    end else if (tick) begin
      qcnt_reg <= 8'(QTR_CYC - 1); // R3
    end else begin
      qcnt_reg <= qcnt_reg - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  ims_pkg::ims_mst_t state_reg;
  ims_pkg::ims_op_t  op_reg;
  logic [1:0]        ph_reg;
  logic [3:0]        bit_reg;
  logic [7:0]        sh_reg;
  logic              ack_reg;
  logic              scl_reg;
  logic              oe_reg;
  logic              take;
  logic              is_tx;

  assign take  = wr & (addr == ims_pkg::REG_CMD) & (state_reg == ims_pkg::IMS_M_IDLE);
  assign is_tx = (op_reg == ims_pkg::IMS_OP_START) | (op_reg == ims_pkg::IMS_OP_TX);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ims_pkg::IMS_M_IDLE;
      op_reg    <= ims_pkg::IMS_OP_NONE;
      ph_reg    <= 2'h0;
      bit_reg   <= 4'h0;
      sh_reg    <= 8'h00;
      ack_reg   <= 1'b0;
      scl_reg   <= 1'b1;
      oe_reg    <= 1'b0;
    end else if (take) begin
      // commands arriving while busy are dropped
      op_reg <= ims_pkg::ims_op_t'(wdata[ims_pkg::CMD_OP_LSB +: 3]);
      sh_reg <= wdata[7:0];
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      case (wdata[ims_pkg::CMD_OP_LSB +: 3])
        ims_pkg::IMS_OP_START:   state_reg <= ims_pkg::IMS_M_START;
        ims_pkg::IMS_OP_STOP:    state_reg <= ims_pkg::IMS_M_STOP;
        ims_pkg::IMS_OP_TX,
        ims_pkg::IMS_OP_RX_ACK,
        ims_pkg::IMS_OP_RX_NACK: state_reg <= ims_pkg::IMS_M_BITS;
        default:                 state_reg <= ims_pkg::IMS_M_IDLE;
      endcase
    end else if (tick) begin
      ph_reg <= ph_reg + 2'h1;
      case (state_reg)
        ims_pkg::IMS_M_START: begin
          case (ph_reg)
            2'h0: oe_reg <= 1'b0;
            2'h1: scl_reg <= 1'b1;
            2'h2: oe_reg <= 1'b1; // R5
            default: begin
              // clock low again before the first data bit may move
              scl_reg   <= 1'b0; // R4
              state_reg <= ims_pkg::IMS_M_IDLE;
            end
          endcase
        end
        ims_pkg::IMS_M_BITS: begin
          case (ph_reg)
            2'h0: begin
              // data moves only a quarter after scl fell
              if (bit_reg == ims_pkg::ACK_BIT) begin
                oe_reg <= ~is_tx & (op_reg == ims_pkg::IMS_OP_RX_ACK); // R7 R8
              end else begin
                oe_reg <= is_tx & ~sh_reg[7]; // R4
              end
            end
            2'h1: scl_reg <= 1'b1; // R3
            2'h2: begin
              if (bit_reg == ims_pkg::ACK_BIT) begin
                ack_reg <= ~sda_s_reg; // R7
              end else begin
                sh_reg <= {sh_reg[6:0], sda_s_reg};
              end
            end
            default: begin
              scl_reg <= 1'b0;
              if (bit_reg == ims_pkg::ACK_BIT) begin
                oe_reg    <= 1'b0; // R10
                state_reg <= ims_pkg::IMS_M_IDLE;
              end else begin
                bit_reg <= bit_reg + 4'h1;
              end
            end
          endcase
        end
        ims_pkg::IMS_M_STOP: begin
          case (ph_reg)
            2'h0: begin
              oe_reg  <= 1'b1;
              scl_reg <= 1'b0;
            end
            2'h1: scl_reg <= 1'b1;
            2'h2: oe_reg <= 1'b0; // R6
            default: state_reg <= ims_pkg::IMS_M_IDLE;
          endcase
        end
        default: ph_reg <= 2'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 32'h0000_0000;
    end else if (rd && addr == ims_pkg::REG_STATUS) begin
      rdata <= 32'h0000_0000;
      rdata[ims_pkg::ST_BUSY]        <= (state_reg != ims_pkg::IMS_M_IDLE);
      rdata[ims_pkg::ST_ACK]         <= ack_reg;
      rdata[ims_pkg::ST_RX_LSB +: 8] <= sh_reg;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  assign link.scl        = scl_reg;
  assign link.mst_sda_oe = oe_reg;
  assign link.mst_sda_o  = 1'b0;

endmodule

//--- core/ims_pkg.sv
// shared constants and types for the two-wire memory slave link
package ims_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SCL_PERIOD_NS  = 1600;
  localparam int SCL_QTR_CYC    = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // serial framing
  // ----------------------------------------------------------------
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT       = 4'h8;
  localparam logic [1:0] IDX_DEV       = 2'h0;
  localparam logic [1:0] IDX_ADDR_HI   = 2'h1;
  localparam logic [1:0] IDX_ADDR_LO   = 2'h2;
  localparam logic [1:0] IDX_DATA      = 2'h3;
  // arbitrary type code, not tied to any real part
  localparam logic [3:0] TYPE_CODE_DFLT = 4'h6;
  localparam int         MEM_DEPTH      = 32768;

  // ----------------------------------------------------------------
  // controller registers
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int         CMD_OP_LSB = 8;
  localparam int         ST_BUSY    = 0;
  localparam int         ST_ACK     = 1;
  localparam int         ST_RX_LSB  = 8;

  typedef enum logic [2:0] {
    IMS_OP_NONE    = 3'h0,
    IMS_OP_START   = 3'h1,
    IMS_OP_TX      = 3'h2,
    IMS_OP_RX_ACK  = 3'h3,
    IMS_OP_RX_NACK = 3'h4,
    IMS_OP_STOP    = 3'h5
  } ims_op_t;

  typedef enum logic [1:0] {
    IMS_D_IDLE = 2'h0,
    IMS_D_RX   = 2'h1,
    IMS_D_TX   = 2'h2
  } ims_dst_t;

  typedef enum logic [1:0] {
    IMS_M_IDLE  = 2'h0,
    IMS_M_START = 2'h1,
    IMS_M_BITS  = 2'h2,
    IMS_M_STOP  = 2'h3
  } ims_mst_t;

endpackage

//--- verification/i2c_memory_slave_front_end_tb.sv
// self-checking bench: controller and slave joined over the two-wire link
`timescale 1ns/1ps
module i2c_memory_slave_front_end_tb;
  localparam logic [2:0] STRAPS = 3'h5;
  localparam logic [3:0] TC     = ims_pkg::TYPE_CODE_DFLT;
  logic        clk;
  logic        rst_b;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        wp;
  logic        active;
  logic [31:0] st;
  int          miscompares;
  int          comparisons;

  ims_link_if link ();
  ims_mst u_ims_mst (.clk(clk), .rst_b(rst_b), .link(link.mst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  ims_dev u_ims_dev (.clk(clk), .rst_b(rst_b), .link(link.dev),
    .select_strap_inputs(STRAPS), .write_protect(wp), .active(active));
  ims_link_chk #(.TYPE_CODE(TC), .SEL(STRAPS)) u_ims_link_chk (.clk(clk),
    .rst_b(rst_b), .scl(link.scl), .sda(link.sda), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .mst_sda_o(link.mst_sda_o),
    .mst_sda_oe(link.mst_sda_oe));

  always #(ims_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  task automatic chkb(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic chkw(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // one controller command, then poll until it is no longer busy
  task automatic op(input ims_pkg::ims_op_t o, input logic [7:0] b);
    int n;
    reg_wr(ims_pkg::REG_CMD, {21'h0, o, b});
    st = 32'h1;
    n  = 0;
    while (st[ims_pkg::ST_BUSY] !== 1'b0 && n < 500) begin
      reg_rd(ims_pkg::REG_STATUS, st);
      n++;
    end
    chkb(st[ims_pkg::ST_BUSY], 1'b0, "controller idle");
    // slave sees the link through two flops, so let it settle
    #(4 * ims_pkg::CLK_PERIOD_NS);
  endtask
  task automatic send(input logic [7:0] b, input logic ack);
    op(ims_pkg::IMS_OP_TX, b);
    chkb(st[ims_pkg::ST_ACK], ack, "ack on ninth clock");
  endtask
  task automatic recv(input logic last, input logic [7:0] exp);
    op(last ? ims_pkg::IMS_OP_RX_NACK : ims_pkg::IMS_OP_RX_ACK, 8'h00);
    chkw({24'h0, st[15:8]}, {24'h0, exp}, "read byte");
  endtask
  task automatic open_dev(input logic [3:0] t, input logic [2:0] s, input logic rw,
                          input logic ack);
    op(ims_pkg::IMS_OP_START, 8'h00);
    send({t, s, rw}, ack);
  endtask
  task automatic stop();
    op(ims_pkg::IMS_OP_STOP, 8'h00);
  endtask

  task automatic tally_and_finish();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // sequence needs well under 20000 clocks
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    clk         = 1'b0;
    rst_b       = 1'b0;
    addr        = 4'h0;
    wdata       = 32'h0;
    wr          = 1'b0;
    rd          = 1'b0;
    wp          = 1'b0;
    st          = 32'h0;
    miscompares = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    reg_rd(ims_pkg::REG_STATUS, st);
    chkw(st, 32'h0, "status after reset");
    reg_wr(4'hc, 32'hffff_ffff);
    reg_rd(4'hc, st);
    chkw(st, 32'h0, "unmapped read");
    for (int s = 0; s < 8; s++) begin
      open_dev(TC, 3'(s), 1'b0, 3'(s) == STRAPS);
      chkb(active, 3'(s) == STRAPS, "slave selected");
      stop();
      chkb(active, 1'b0, "standby after stop");
    end
    open_dev(~TC, STRAPS, 1'b0, 1'b0);
    chkb(active, 1'b0, "wrong type ignored");
    stop();
    // write two bytes, then read them back across a repeated start
    open_dev(TC, STRAPS, 1'b0, 1'b1);
    send(8'h01, 1'b1);
    send(8'h23, 1'b1);
    send(8'ha5, 1'b1);
    send(8'h5a, 1'b1);
    stop();
    open_dev(TC, STRAPS, 1'b0, 1'b1);
    send(8'h01, 1'b1);
    send(8'h23, 1'b1);
    open_dev(TC, STRAPS, 1'b1, 1'b1);
    recv(1'b0, 8'ha5);
    recv(1'b1, 8'h5a);
    chkb(active, 1'b0, "released after nack");
    stop();
    // last location wraps to zero; top address bit is ignored
    open_dev(TC, STRAPS, 1'b0, 1'b1);
    send(8'h7f, 1'b1);
    send(8'hff, 1'b1);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    stop();
    open_dev(TC, STRAPS, 1'b0, 1'b1);
    send(8'hff, 1'b1);
    send(8'hff, 1'b1);
    open_dev(TC, STRAPS, 1'b1, 1'b1);
    recv(1'b0, 8'h11);
    recv(1'b1, 8'h22);
    stop();
    // protected write is acknowledged but leaves the array alone
    wp <= 1'b1;
    repeat (3) @(posedge clk);
    open_dev(TC, STRAPS, 1'b0, 1'b1);
    send(8'h01, 1'b1);
    send(8'h23, 1'b1);
    send(8'hff, 1'b1);
    stop();
    open_dev(TC, STRAPS, 1'b0, 1'b1);
    send(8'h01, 1'b1);
    send(8'h23, 1'b1);
    open_dev(TC, STRAPS, 1'b1, 1'b1);
    recv(1'b1, 8'ha5);
    stop();
    wp <= 1'b0;
    tally_and_finish();
  end
endmodule

//--- verification/ims_link_chk.sv
// concurrent checks on the two-wire link between controller and slave
`timescale 1ns/1ps
module ims_link_chk #(
  parameter logic [3:0] TYPE_CODE = ims_pkg::TYPE_CODE_DFLT, // expected type code
  parameter logic [2:0] SEL       = 3'h0                     // slave strap levels
) (
  input wire logic clk,        // system clock
  input wire logic rst_b,      // async reset, active low
  input wire logic scl,        // serial clock
  input wire logic sda,        // resolved data line
  input wire logic dev_sda_o,  // slave data out
  input wire logic dev_sda_oe, // slave pulls line
  input wire logic mst_sda_o,  // controller data out
  input wire logic mst_sda_oe  // controller pulls line
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic       first;
  logic       sel;
  logic       rw;
  wire        rise  = scl & ~scl_q;
  wire        start = scl & scl_q & sda_q & ~sda;
  wire        stop  = scl & scl_q & ~sda_q & sda;
  wire        match = (sh[7:4] == TYPE_CODE) && (sh[3:1] == SEL);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // --------------------------------------------------------------
  // bit position inside the nine-clock group
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 4'h0;
      sh  <= 8'h00;
    end else if (start) begin
      cnt <= 4'h0;
    end else if (rise) begin
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt != 4'h8) begin
        sh <= {sh[6:0], sda};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first <= 1'b0;
      sel   <= 1'b0;
      rw    <= 1'b0;
    end else if (start) begin
      first <= 1'b1;
      sel   <= 1'b0;
    end else if (stop) begin
      first <= 1'b0;
      sel   <= 1'b0;
    end else if (rise && cnt == 4'h8) begin
      first <= 1'b0;
      if (first) begin
        sel <= match;
        rw  <= sh[0];
      end else if (rw && sda) begin
        sel <= 1'b0; // controller nack ends the read
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_pull_only: assert property (!dev_sda_o && !mst_sda_o)
    else $error("data driver not pulling low");
  a_drive_on_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("slave changed data while clock high");
  a_ack_hold: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
    else $error("slave low drive too short");
  a_addr_ack: assert property (rise && first && cnt == 4'h8 |-> dev_sda_oe == match)
    else $error("address word answered wrongly");
  a_unsel_quiet: assert property (rise && !first && !sel |-> !dev_sda_oe)
    else $error("unselected slave drove data");
  a_rx_bits_free: assert property
    (rise && cnt != 4'h8 && (first || (sel && !rw)) |-> !dev_sda_oe)
    else $error("slave drove data while receiving");
  a_wr_data_ack: assert property (rise && !first && sel && !rw && cnt == 4'h8 |-> dev_sda_oe)
    else $error("written byte not acknowledged");
  a_rd_ack_free: assert property (rise && !first && sel && rw && cnt == 4'h8 |-> !dev_sda_oe)
    else $error("slave held data on read ack clock");
  a_start_quiet: assert property (start |-> !dev_sda_oe [*8])
    else $error("slave drove data after start");
  a_stop_idle: assert property (stop |=> !dev_sda_oe [*8])
    else $error("slave drove data after stop");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*4])
    else $error("serial clock high phase too short");
endmodule
